/* pmc_pll_pd_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module pmc_pll_pd_ctrl
#(
    parameter int unsigned LOCK_CYC  = pmc_pkg::LOCK_CYCLES,
    parameter int unsigned ENTRY_CYC = pmc_pkg::PD_ENTRY_CYCLES
)
(
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [pmc_pkg::ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    // strap pins
    input  wire logic                        mode_strap_high_i,
    input  wire logic                        mode_strap_low_i,
    // interrupt state from the core
    input  wire logic                        irq_pending_i,
    input  wire logic                        irq_enabled_i,
    // clock control
    output logic      [pmc_pkg::MULT_W-1:0]  pll_mult_o,
    output logic                             pll_locked_o,
    output logic                             strap_reserved_o,
    output logic                             pll_in_run_o,
    output logic                             pll_out_run_o,
    output logic                             cpu_clk_en_o,
    output logic                             int_clk_en_o,
    output logic                             dma_clk_en_o,
    output logic                             io_freeze_o,
    output logic                             quarter_rate_clock_out_o,
    output logic                             sixth_rate_clock_out_o
);
    import pmc_pkg::*;

    // ****************************************************************
    // strap synchroniser
    // ****************************************************************
    logic [1:0] strap_s1_reg, strap_s1_next;
    logic [1:0] strap_s2_reg, strap_s2_next;
    logic [1:0] fill_reg,     fill_next;

    always_comb
    begin
        strap_s1_next = {mode_strap_high_i, mode_strap_low_i};
        strap_s2_next = strap_s1_reg;
        fill_next     = {fill_reg[0], 1'b1};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            strap_s1_reg <= STRAP_BYPASS;
            strap_s2_reg <= STRAP_BYPASS;
            fill_reg     <= 2'h0;
        end
        else
        begin
            strap_s1_reg <= strap_s1_next;
            strap_s2_reg <= strap_s2_next;
            fill_reg     <= fill_next;
        end
    end

    // ****************************************************************
    // mode decode and lock wait
    // ****************************************************************
    logic [1:0]        mode_seen_reg, mode_seen_next;
    logic              lock_reg,      lock_next;
    logic [LOCK_W-1:0] lock_cnt_reg,  lock_cnt_next;
    logic [MULT_W-1:0] mult_reg,      mult_next;
    logic              rsvd_reg,      rsvd_next;
    logic              is_mult;

    always_comb
    begin
        is_mult        = (strap_s2_reg == STRAP_X6) || (strap_s2_reg == STRAP_X12);
        mode_seen_next = strap_s2_reg;
        lock_next      = lock_reg;
        lock_cnt_next  = lock_cnt_reg;
        rsvd_next      = (strap_s2_reg == STRAP_RSVD);
        unique case (strap_s2_reg)
            STRAP_X6:  mult_next = MULT_X6;
            STRAP_X12: mult_next = MULT_X12;
            default:   mult_next = MULT_X1;
        endcase
        // lock is held low until the synchroniser has filled
        if (!fill_reg[1])
        begin
            lock_next = 1'b0;
        end
        else if (strap_s2_reg != mode_seen_reg)
        begin
            // a new selection restarts the wait; bypass needs none
            lock_next     = !is_mult;
            lock_cnt_next = LOCK_W'(LOCK_CYC - 1);
        end
        else if (!is_mult)
        begin
            lock_next = 1'b1;
        end
        else if (!lock_reg)
        begin
            if (lock_cnt_reg == '0)
                lock_next = 1'b1;
            else
                lock_cnt_next = lock_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_seen_reg <= STRAP_BYPASS;
            lock_reg      <= 1'b0;
            lock_cnt_reg  <= LOCK_W'(LOCK_CYC - 1);
            mult_reg      <= MULT_X1;
            rsvd_reg      <= 1'b0;
        end
        else
        begin
            mode_seen_reg <= mode_seen_next;
            lock_reg      <= lock_next;
            lock_cnt_reg  <= lock_cnt_next;
            mult_reg      <= mult_next;
            rsvd_reg      <= rsvd_next;
        end
    end

    // ****************************************************************
    // wishbone slave and power-down state
    // ****************************************************************
    pmc_pd_state_e       ps_reg,     ps_next;
    logic [PD_W-1:0]     pd_reg,     pd_next;
    logic [PD_CNT_W-1:0] pd_cnt_reg, pd_cnt_next;
    logic                ack_reg,    ack_next;
    logic [31:0]         dat_reg,    dat_next;
    logic                req;
    logic                commit;
    logic                wake;
    logic                legal;

    always_comb
    begin
        req      = wb_cyc_i && wb_stb_i;
        ack_next = req && !ack_reg;
        dat_next = 32'h0;
        if (req && !ack_reg)
        begin
            if (wb_adr_i == CSR_OFS)
                dat_next[PD_MSB:PD_LSB] = pd_reg;
            else if (wb_adr_i == STATUS_OFS)
            begin
                dat_next[ST_LOCK]                 = lock_reg;
                dat_next[ST_MODE_MSB:ST_MODE_LSB] = strap_s2_reg;
                dat_next[ST_RSVD]                 = rsvd_reg;
                dat_next[ST_HALT]                 = (ps_reg == PS_HALT);
                dat_next[ST_DEEP]                 = (ps_reg == PS_DEEP);
            end
        end
        // the write lands at the edge where the master sees ack; a chip in deep power-down takes none
        commit = req && ack_reg && wb_we_i && (wb_adr_i == CSR_OFS) && wb_sel_i[PD_SEL_BYTE]
                 && (ps_reg != PS_DEEP);
        wake   = irq_pending_i && ((pd_reg == PD_HALT_ANY) || irq_enabled_i);
        legal  = (wb_dat_i[PD_MSB:PD_LSB] == PD_HALT_EN) || (wb_dat_i[PD_MSB:PD_LSB] == PD_HALT_ANY) ||
                 (wb_dat_i[PD_MSB:PD_LSB] == PD_PLL_OUT) || (wb_dat_i[PD_MSB:PD_LSB] == PD_PLL_IN);
        ps_next     = ps_reg;
        pd_next     = pd_reg;
        pd_cnt_next = pd_cnt_reg;
        if (commit)
            pd_next = wb_dat_i[PD_MSB:PD_LSB];
        unique case (ps_reg)
            PS_RUN, PS_ARM:
            begin
                if (commit)
                begin
                    // reserved codes are kept but select nothing
                    ps_next     = legal ? PS_ARM : PS_RUN;
                    pd_cnt_next = PD_CNT_W'(ENTRY_CYC - 1);
                end
                else if (ps_reg == PS_ARM)
                begin
                    if (pd_cnt_reg == '0)
                        ps_next = ((pd_reg == PD_PLL_OUT) || (pd_reg == PD_PLL_IN)) ?
                                  PS_DEEP : PS_HALT;
                    else
                        pd_cnt_next = pd_cnt_reg - 1'b1;
                end
            end
            PS_HALT:
            begin
                // a software write in the same cycle keeps its own value
                if (wake && !commit)
                begin
                    ps_next = PS_RUN;
                    pd_next = PD_NONE;
                end
                else if (commit)
                begin
                    ps_next     = legal ? PS_ARM : PS_RUN;
                    pd_cnt_next = PD_CNT_W'(ENTRY_CYC - 1);
                end
            end
            PS_DEEP:
                ps_next = PS_DEEP;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ps_reg     <= PS_RUN;
            pd_reg     <= PD_RESET;
            pd_cnt_reg <= '0;
            ack_reg    <= 1'b0;
            dat_reg    <= 32'h0;
        end
        else
        begin
            ps_reg     <= ps_next;
            pd_reg     <= pd_next;
            pd_cnt_reg <= pd_cnt_next;
            ack_reg    <= ack_next;
            dat_reg    <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ****************************************************************
    // clock enables and derived clocks
    // ****************************************************************
    logic             cpu_en_reg, cpu_en_next;
    logic             sys_en_reg, sys_en_next;
    logic             pin_reg,    pin_next;
    logic             pout_reg,   pout_next;
    logic             frz_reg,    frz_next;
    logic [DIV_W-1:0] qcnt_reg,   qcnt_next;
    logic [DIV_W-1:0] scnt_reg,   scnt_next;
    logic             q_reg,      q_next;
    logic             s_reg,      s_next;
    logic             div_en;

    always_comb
    begin
        // cpu, int and dma enables all wait for lock; cpu also stops in halt, int and dma only in deep
        cpu_en_next = lock_next && ((ps_next == PS_RUN) || (ps_next == PS_ARM));
        sys_en_next = lock_next && (ps_next != PS_DEEP);
        pout_next   = (ps_next != PS_DEEP);
        pin_next    = !((ps_next == PS_DEEP) && (pd_next == PD_PLL_IN));
        frz_next    = (ps_next == PS_DEEP);
        div_en      = sys_en_next;
        qcnt_next   = qcnt_reg;
        scnt_next   = scnt_reg;
        q_next      = q_reg;
        s_next      = s_reg;
        if (div_en)
        begin
            if (qcnt_reg == QUARTER_HALF - 1'b1)
            begin
                qcnt_next = '0;
                q_next    = !q_reg;
            end
            else
                qcnt_next = qcnt_reg + 1'b1;
            if (scnt_reg == SIXTH_HALF - 1'b1)
            begin
                scnt_next = '0;
                s_next    = !s_reg;
            end
            else
                scnt_next = scnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cpu_en_reg <= 1'b0;
            sys_en_reg <= 1'b0;
            pin_reg    <= 1'b1;
            pout_reg   <= 1'b1;
            frz_reg    <= 1'b0;
            qcnt_reg   <= '0;
            scnt_reg   <= '0;
            q_reg      <= 1'b0;
            s_reg      <= 1'b0;
        end
        else
        begin
            cpu_en_reg <= cpu_en_next;
            sys_en_reg <= sys_en_next;
            pin_reg    <= pin_next;
            pout_reg   <= pout_next;
            frz_reg    <= frz_next;
            qcnt_reg   <= qcnt_next;
            scnt_reg   <= scnt_next;
            q_reg      <= q_next;
            s_reg      <= s_next;
        end
    end

    assign pll_mult_o               = mult_reg;
    assign pll_locked_o             = lock_reg;
    assign strap_reserved_o         = rsvd_reg;
    assign pll_in_run_o             = pin_reg;
    assign pll_out_run_o            = pout_reg;
    assign cpu_clk_en_o             = cpu_en_reg;
    assign int_clk_en_o             = sys_en_reg;
    assign dma_clk_en_o             = sys_en_reg;
    assign io_freeze_o              = frz_reg;
    assign quarter_rate_clock_out_o = q_reg;
    assign sixth_rate_clock_out_o   = s_reg;

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_mult_decode;
        @(posedge clk_i) disable iff (rst_i)
        (strap_s2_reg == STRAP_X12) |=> (pll_mult_o == MULT_X12);
    endproperty
    a_mult_decode: assert property (p_mult_decode) else $error("x12 strap not decoded");

    property p_bypass_lock;
        @(posedge clk_i) disable iff (rst_i)
        (fill_reg[1] && strap_s2_reg == STRAP_BYPASS) [*2] |=> pll_locked_o;
    endproperty
    a_bypass_lock: assert property (p_bypass_lock) else $error("bypass mode not locked at once");

    property p_lock_gate;
        @(posedge clk_i) disable iff (rst_i)
        !pll_locked_o |-> !cpu_clk_en_o && !int_clk_en_o;
    endproperty
    a_lock_gate: assert property (p_lock_gate) else $error("clocks enabled before lock");

    property p_lock_restart;
        @(posedge clk_i) disable iff (rst_i)
        (fill_reg[1] && $changed(strap_s2_reg) && strap_s2_reg == STRAP_X6) |=> !pll_locked_o [*8];
    endproperty
    a_lock_restart: assert property (p_lock_restart) else $error("lock wait skipped");

    property p_field_write;
        @(posedge clk_i) disable iff (rst_i)
        (commit && ps_reg != PS_HALT) |=> (pd_reg == $past(wb_dat_i[PD_MSB:PD_LSB]));
    endproperty
    a_field_write: assert property (p_field_write) else $error("power-down field not written");

    property p_reset_zero;
        @(posedge clk_i) rst_i |=> (pd_reg == PD_RESET) && (ps_reg == PS_RUN);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("power-down field not zero after reset");

    property p_rsvd_code;
        @(posedge clk_i) disable iff (rst_i)
        (commit && ps_reg == PS_RUN && !legal) |=> (ps_reg == PS_RUN);
    endproperty
    a_rsvd_code: assert property (p_rsvd_code) else $error("reserved code changed state");

    property p_halt_gate;
        @(posedge clk_i) disable iff (rst_i)
        (ps_reg == PS_HALT) |-> !cpu_clk_en_o && (int_clk_en_o == pll_locked_o) && (dma_clk_en_o == int_clk_en_o);
    endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("halt gating wrong");

    property p_deep_hold;
        @(posedge clk_i) disable iff (rst_i)
        (ps_reg == PS_DEEP) |=> io_freeze_o && !pll_out_run_o && (ps_reg == PS_DEEP) && !int_clk_en_o;
    endproperty
    a_deep_hold: assert property (p_deep_hold) else $error("deep mode left or not frozen");

    property p_entry_delay;
        @(posedge clk_i) disable iff (rst_i)
        (commit && wb_dat_i[PD_MSB:PD_LSB] == PD_PLL_OUT) |=> !io_freeze_o [*8] ##1 !io_freeze_o ##1 io_freeze_o;
    endproperty
    a_entry_delay: assert property (p_entry_delay) else $error("mode entry not nine cycles after write");

    property p_quarter;
        @(posedge clk_i) disable iff (rst_i)
        ($rose(quarter_rate_clock_out_o) && div_en) ##1 div_en |=> $fell(quarter_rate_clock_out_o);
    endproperty
    a_quarter: assert property (p_quarter) else $error("quarter clock high time wrong");

    property p_sixth;
        @(posedge clk_i) disable iff (rst_i)
        ($rose(sixth_rate_clock_out_o) && div_en) ##1 div_en [*2] |=> $fell(sixth_rate_clock_out_o);
    endproperty
    a_sixth: assert property (p_sixth) else $error("sixth clock high time wrong");

endmodule

`default_nettype wire

/* pmc_pkg.sv */
package pmc_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned LOCK_TYP_NS     = 75000;
    localparam int unsigned LOCK_MARGIN_PCT = 150;
    // worst-case lock time is the typical figure plus the margin, rounded up to cycles
    localparam int unsigned LOCK_MAX_NS     = LOCK_TYP_NS * (100 + LOCK_MARGIN_PCT) / 100;
    localparam int unsigned LOCK_CYCLES     = (LOCK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOCK_W          = 12;
    localparam int unsigned PD_ENTRY_CYCLES = 9;
    localparam int unsigned PD_CNT_W        = 4;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int unsigned ADR_W      = 4;
    localparam logic [3:0]  CSR_OFS    = 4'h0;
    localparam logic [3:0]  STATUS_OFS = 4'h4;
    localparam int unsigned PD_LSB     = 10;
    localparam int unsigned PD_MSB     = 15;
    localparam int unsigned PD_W       = 6;
    localparam int unsigned PD_SEL_BYTE = 1;
    localparam logic [5:0]  PD_RESET   = 6'h00;
    localparam int unsigned ST_LOCK    = 0;
    localparam int unsigned ST_MODE_LSB = 1;
    localparam int unsigned ST_MODE_MSB = 2;
    localparam int unsigned ST_RSVD    = 3;
    localparam int unsigned ST_HALT    = 4;
    localparam int unsigned ST_DEEP    = 5;

    // ****************************************************************
    // power-down codes
    // ****************************************************************
    localparam logic [5:0] PD_NONE     = 6'h00;
    localparam logic [5:0] PD_HALT_EN  = 6'h09;
    localparam logic [5:0] PD_HALT_ANY = 6'h11;
    localparam logic [5:0] PD_PLL_OUT  = 6'h1a;
    localparam logic [5:0] PD_PLL_IN   = 6'h1c;

    // ****************************************************************
    // strap modes and multiply factors
    // ****************************************************************
    localparam logic [1:0] STRAP_BYPASS = 2'h0;
    localparam logic [1:0] STRAP_X6     = 2'h1;
    localparam logic [1:0] STRAP_X12    = 2'h2;
    localparam logic [1:0] STRAP_RSVD   = 2'h3;
    localparam int unsigned MULT_W      = 4;
    localparam logic [3:0] MULT_X1      = 4'h1;
    localparam logic [3:0] MULT_X6      = 4'h6;
    localparam logic [3:0] MULT_X12     = 4'hc;

    // ****************************************************************
    // output clock dividers (half periods)
    // ****************************************************************
    localparam int unsigned DIV_W        = 2;
    localparam logic [1:0]  QUARTER_HALF = 2'h2;
    localparam logic [1:0]  SIXTH_HALF   = 2'h3;

    typedef enum logic [1:0] {PS_RUN, PS_ARM, PS_HALT, PS_DEEP} pmc_pd_state_e;

endpackage

/* pmc_strap_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// strap resistors behind the clock-mode pins
// ****************************************************************
module pmc_strap_model
(
    // requested mode
    input  wire logic [1:0] mode_i,
    input  wire logic       rsvd_ok_i,
    // strap levels
    output logic            strap_high_o,
    output logic            strap_low_o
);
    // pull-downs win unless a valid pull-up is fitted, so the default is bypass
    always_comb
    begin
        {strap_high_o, strap_low_o} = mode_i;
        if (mode_i == 2'h3 && !rsvd_ok_i)
        begin
            {strap_high_o, strap_low_o} = 2'h0;
        end
    end
endmodule

`default_nettype wire

/* tb_pll_mode_and_power_down_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_pll_mode_and_power_down_ctrl;
    import pmc_pkg::*;
    localparam int LCK = 20;
    // en holds cpu, int, freeze, pll input run
    typedef struct packed {logic [1:0] st; logic [5:0] code; logic [3:0] mlt; logic [3:0] en;} pmc_row_s;
    pmc_row_s rows [7] = '{'{2'h0, 6'h00, 4'h1, 4'hd}, '{2'h1, 6'h09, 4'h6, 4'h5}, '{2'h2, 6'h11, 4'hc, 4'h5},
        '{2'h1, 6'h1a, 4'h6, 4'h3}, '{2'h2, 6'h1c, 4'hc, 4'h2}, '{2'h3, 6'h00, 4'h1, 4'hd}, '{2'h0, 6'h1f, 4'h1, 4'hd}};
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, irq_p = 1'b0, irq_e = 1'b0, ok = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'hf, mult;
    logic [31:0] dat = 32'h0, rdat, rd;
    logic [1:0] mode = 2'h0;
    logic ack, lck, rsv, in_run, out_run, cpu_en, int_en, dma_en, frz, q_clk, s_clk, s_hi, s_lo;
    int fails = 0, checked = 0, n, p;

    always #50 clk_i = ~clk_i;

    pmc_strap_model strap (.mode_i(mode), .rsvd_ok_i(ok), .strap_high_o(s_hi), .strap_low_o(s_lo));
    pmc_pll_pd_ctrl #(.LOCK_CYC(LCK)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mode_strap_high_i(s_hi), .mode_strap_low_i(s_lo), .irq_pending_i(irq_p), .irq_enabled_i(irq_e),
        .pll_mult_o(mult), .pll_locked_o(lck), .strap_reserved_o(rsv), .pll_in_run_o(in_run),
        .pll_out_run_o(out_run), .cpu_clk_en_o(cpu_en), .int_clk_en_o(int_en), .dma_clk_en_o(dma_en),
        .io_freeze_o(frz), .quarter_rate_clock_out_o(q_clk), .sixth_rate_clock_out_o(s_clk));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // request held until ack is sampled high, then released
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        // no cycle count is assumed; only the watchdog ends a wait that never sees ack
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        rd = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // cycles from one rising edge of a divided clock to the next
    task automatic period(input logic six, output int q);
        int r;
        logic a, b;
        r = 0;
        q = 0;
        a = 1'b1;
        for (int k = 0; k < 40 && r < 2; k++)
        begin
            tick(1);
            b = six ? s_clk : q_clk;
            if (r == 1) q++;
            if (b && !a) r++;
            a = b;
        end
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial
    begin
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk_i);
            mode <= rows[i].st;
            ok <= (rows[i].st == 2'h3);
            do_reset();
            n = 0;
            while (lck !== 1'b1 && n < 200)
            begin
                @(posedge clk_i);
                n++;
            end
            chk("locked", 1, lck);
            chk("lock_wait", 1, (rows[i].mlt != 4'h1) == (n >= LCK));
            chk("mult", rows[i].mlt, mult);
            chk("strap_rsvd", rows[i].st == 2'h3, rsv);
            wb(1'b1, CSR_OFS, 32'(rows[i].code) << 10, 4'hf);
            tick(8);
            chk("pre_entry", 1, cpu_en);
            tick(1);
            chk("pd_en", rows[i].en, {cpu_en, int_en, frz, in_run});
            chk("pd_aux", {~rows[i].en[1], rows[i].en[2]}, {out_run, dma_en});
            wb(1'b0, CSR_OFS, 32'h0, 4'hf);
            chk("field", 32'(rows[i].code) << 10, rd);
            // status: deep, halted, straps reserved, synced straps, locked
            wb(1'b0, STATUS_OFS, 32'h0, 4'hf);
            chk("status", {26'h0, rows[i].en[1], ~rows[i].en[3] & ~rows[i].en[1], rows[i].st == 2'h3,
                rows[i].st, 1'b1}, rd);
        end
        do_reset();
        tick(1);
        chk("rst_out", 6'h04, {mult, cpu_en, frz});
        wb(1'b0, CSR_OFS, 32'h0, 4'hf);
        chk("rst_field", 0, rd);
        // a write without the field's byte lane must leave it alone
        wb(1'b1, CSR_OFS, 32'h2400, 4'hd);
        wb(1'b0, CSR_OFS, 32'h0, 4'hf);
        chk("lane", 0, rd);
        wb(1'b1, 4'h8, 32'hffff_ffff, 4'hf);
        wb(1'b0, 4'h8, 32'h0, 4'hf);
        chk("unmapped", 0, rd);
        wb(1'b1, CSR_OFS, 32'h2400, 4'hf);
        tick(12);
        @(posedge clk_i);
        irq_p <= 1'b1;
        tick(3);
        chk("no_wake", 0, cpu_en);
        @(posedge clk_i);
        irq_e <= 1'b1;
        tick(2);
        chk("wake_en", 1, cpu_en);
        wb(1'b0, CSR_OFS, 32'h0, 4'hf);
        chk("wake_clr", 0, rd);
        @(posedge clk_i);
        {irq_p, irq_e} <= 2'b00;
        wb(1'b1, CSR_OFS, 32'h4400, 4'hf);
        tick(12);
        chk("halt_any", 0, cpu_en);
        @(posedge clk_i);
        irq_p <= 1'b1;
        tick(2);
        chk("wake_any", 1, cpu_en);
        period(1'b0, p);
        chk("quarter", 4, p);
        period(1'b1, p);
        chk("sixth", 6, p);
        wb(1'b1, CSR_OFS, 32'h6800, 4'hf);
        tick(10);
        wb(1'b1, CSR_OFS, 32'h0, 4'hf);
        tick(12);
        chk("deep_hold", 4'h3, {cpu_en, int_en, frz, in_run});
        // a write while deep must not reach the field
        wb(1'b0, CSR_OFS, 32'h0, 4'hf);
        chk("deep_field", 32'h6800, rd);
        do_reset();
        tick(1);
        chk("deep_exit", 0, frz);
        stop_test();
    end

    initial
    begin
        #2000000;
        fails++;
        stop_test();
    end
endmodule

`default_nettype wire
